//--- rtl/slope_monitor.sv
// hottest-of comparison and temperature slope logic after each conversion
// assumes conversion results arrive as upper bytes with a one-cycle strobe,
// and that the serial front end presents decoded register reads and writes
module slope_monitor
  import slope_mon_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // conversion results
  input wire logic i_conv_done,
  input wire logic [slope_mon_pkg::TW-1:0] i_temp_int,
  input wire logic [slope_mon_pkg::TW-1:0] i_temp_ext1,
  input wire logic [slope_mon_pkg::TW-1:0] i_temp_ext2,
  input wire logic [slope_mon_pkg::TW-1:0] i_temp_ext3,
  input wire logic [slope_mon_pkg::TW-1:0] i_temp_ext4,
  // hottest-of configuration
  input wire logic [slope_mon_pkg::NUM_CH-1:0] i_hot_select,
  input wire logic i_remember_hottest_enable,
  input wire logic i_hot_change_clear,
  // package options
  input wire logic i_second_anti_parallel,
  input wire logic i_single_remote,
  // register port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // hottest results
  output logic [slope_mon_pkg::TW-1:0] o_hottest_temp,
  output logic [slope_mon_pkg::NUM_CH-1:0] o_hottest_status,
  output logic o_hottest_changed,
  // alert pin, low while asserted
  output logic o_alert_n
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  // scaled difference with three fraction bits, saturated to the result
  function automatic logic [QW-1:0] slope_calc(
    input logic [TW-1:0] t_end,
    input logic [TW-1:0] t_start,
    input logic [GAIN_CW-1:0] g,
    input logic [SAMP_CW-1:0] n
  );
    logic signed [19:0] d;
    d = {12'h000, t_end} - {12'h000, t_start};
    d = d <<< (g + FRAC_SHIFT);
    d = d >>> n;
    if (d > Q_MAX) begin
      slope_calc = Q_MAX[QW-1:0];
    end else if (d < Q_MIN) begin
      slope_calc = Q_MIN[QW-1:0];
    end else begin
      slope_calc = d[QW-1:0];
    end
  endfunction
  // signed 9-bit compare: a positive limit trips above, a negative below
  function automatic logic over_limit(
    input logic [8:0] res,
    input logic [8:0] lim
  );
    if (lim[8]) begin
      over_limit = $signed(res) < $signed(lim);
    end else begin
      over_limit = $signed(res) > $signed(lim);
    end
  endfunction
  function automatic logic [TW-1:0] max8(
    input logic [TW-1:0] a,
    input logic [TW-1:0] b
  );
    max8 = (a > b) ? a : b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // programmable registers
  logic [7:0] gain_r;
  logic [7:0] config_r;
  logic [7:0] lim_hi_r [NUM_SLOPE];
  logic [7:0] lim_lo_r [NUM_SLOPE];
  logic [7:0] samples_r [NUM_SLOPE];
  // host writes; unmapped and read-only offsets are ignored
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      gain_r <= REG_RST;
      config_r <= REG_RST;
      for (int i = 0; i < NUM_SLOPE; i++) begin
        lim_hi_r[i] <= REG_RST;
        lim_lo_r[i] <= REG_RST;
        samples_r[i] <= REG_RST;
      end
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        A_GAIN: gain_r <= i_reg_wdata;
        A_CONFIG: config_r <= i_reg_wdata;
        A_LIM_HI_1: lim_hi_r[0] <= i_reg_wdata;
        A_LIM_LO_1: lim_lo_r[0] <= i_reg_wdata;
        A_SAMPLES_1: samples_r[0] <= i_reg_wdata;
        A_LIM_HI_23: lim_hi_r[1] <= i_reg_wdata;
        A_LIM_LO_23: lim_lo_r[1] <= i_reg_wdata;
        A_SAMPLES_23: samples_r[1] <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // hottest-of comparison
  logic [TW-1:0] temp_ch [NUM_CH];
  logic [TW-1:0] hot_max;
  logic [NUM_CH-1:0] hot_tie;
  assign temp_ch[0] = i_temp_int;
  assign temp_ch[1] = i_temp_ext1;
  assign temp_ch[2] = i_temp_ext2;
  assign temp_ch[3] = i_temp_ext3;
  assign temp_ch[4] = i_temp_ext4;
  always_comb begin
    hot_max = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (i_hot_select[i]) begin
        hot_max = max8(hot_max, temp_ch[i]);
      end
    end
  end
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      hot_tie[i] = i_hot_select[i] && (temp_ch[i] == hot_max);
    end
  end
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_hottest_temp <= '0;
      o_hottest_status <= '0;
    end else if (i_conv_done) begin
      o_hottest_temp <= hot_max;
      o_hottest_status <= hot_tie;
    end
  end
  // hottest change event, sticky; a new event beats the clear
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_hottest_changed <= 1'b0;
    end else if (i_conv_done && i_remember_hottest_enable &&
                 (o_hottest_status != '0) && (hot_tie != o_hottest_status)) begin
      o_hottest_changed <= 1'b1;
    end else if (i_hot_change_clear) begin
      o_hottest_changed <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slope channel selection
  logic slope_en;
  logic [NUM_SLOPE-1:0] ch_active;
  logic [TW-1:0] slope_temp [NUM_SLOPE];
  logic [GAIN_CW-1:0] gain_code [NUM_SLOPE];
  logic [SAMP_CW-1:0] samp_code [NUM_SLOPE];
  logic [CFG_HYST_W-1:0] hyst;
  assign slope_en = config_r[CFG_EN_BIT];
  assign hyst = config_r[CFG_HYST_W-1:0];
  // diode three replaces diode two when anti-parallel
  assign slope_temp[0] = temp_ch[CH_EXT1];
  assign slope_temp[1] = i_second_anti_parallel ? temp_ch[CH_EXT3]
                                                : temp_ch[CH_EXT2];
  // single remote variant runs channel one only
  assign ch_active[0] = slope_en;
  assign ch_active[1] = slope_en && !i_single_remote;
  assign gain_code[0] = gain_r[GAIN_CH1_LSB +: GAIN_CW];
  assign gain_code[1] = gain_r[GAIN_CH23_LSB +: GAIN_CW];
  assign samp_code[0] = samples_r[0][SAMP_CW-1:0];
  assign samp_code[1] = samples_r[1][SAMP_CW-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // per-channel slope tracking
  logic [CW-1:0] cnt_r [NUM_SLOPE];
  logic [TW-1:0] start_r [NUM_SLOPE];
  logic [TW-1:0] prev_r [NUM_SLOPE];
  logic [NUM_SLOPE-1:0] dir_down_r;
  logic [TW-1:0] period_max_r [NUM_SLOPE];
  logic [QW-1:0] result_r [NUM_SLOPE];
  // per-conversion decode for each channel
  logic [NUM_SLOPE-1:0] step;
  logic [NUM_SLOPE-1:0] last;
  logic [NUM_SLOPE-1:0] reversal;
  logic [NUM_SLOPE-1:0] exceed;
  logic [TW-1:0] pmax_nxt [NUM_SLOPE];
  logic [QW-1:0] result_nxt [NUM_SLOPE];
  always_comb begin
    logic [8:0] d;
    logic [8:0] mag;
    d = '0;
    mag = '0;
    for (int i = 0; i < NUM_SLOPE; i++) begin
      step[i] = i_conv_done && ch_active[i];
      // period is 2**code + 1 samples, so the last has index 2**code
      last[i] = step[i] && (cnt_r[i] == (CNT_RST | (9'h001 << samp_code[i])));
      d = {1'b0, slope_temp[i]} - {1'b0, prev_r[i]};
      mag = d[8] ? (~d + 9'h001) : d;
      reversal[i] = step[i] && (cnt_r[i] > 9'h001) &&
                    (d[8] != dir_down_r[i]) && (d != '0) &&
                    (mag > {5'h00, hyst});
      pmax_nxt[i] = (cnt_r[i] == CNT_RST) ? slope_temp[i]
                                          : max8(period_max_r[i],
                                                 slope_temp[i]);
      // gained difference over samples minus one
      result_nxt[i] = slope_calc(slope_temp[i], start_r[i], gain_code[i],
                                 samp_code[i]);
      // signed compare of 9-bit result against 9-bit limit
      exceed[i] = last[i] && over_limit(result_nxt[i][QW-1:FRAC_SHIFT],
                                        {lim_hi_r[i], lim_lo_r[i][7]});
    end
  end
  // sample counter, start and previous samples, direction
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dir_down_r <= '0;
      for (int i = 0; i < NUM_SLOPE; i++) begin
        cnt_r[i] <= CNT_RST;
        start_r[i] <= '0;
        prev_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_SLOPE; i++) begin
        if (!ch_active[i]) begin
          cnt_r[i] <= CNT_RST;  // disabled channels restart their period
        end else if (step[i]) begin
          prev_r[i] <= slope_temp[i];
          if (cnt_r[i] == CNT_RST) begin
            start_r[i] <= slope_temp[i];
          end
          // reference direction from first two samples
          if (cnt_r[i] == 9'h001) begin
            dir_down_r[i] <= slope_temp[i] < prev_r[i];
          end else if (reversal[i]) begin
            dir_down_r[i] <= ~dir_down_r[i];
          end
          cnt_r[i] <= last[i] ? CNT_RST : cnt_r[i] + 9'h001;
        end
      end
    end
  end
  // period maximum, restarts with the first sample of a period
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < NUM_SLOPE; i++) begin
        period_max_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_SLOPE; i++) begin
        if (step[i]) begin
          period_max_r[i] <= pmax_nxt[i];
        end
      end
    end
  end
  // result loaded only at a period's last conversion
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < NUM_SLOPE; i++) begin
        result_r[i] <= RES_RST;
      end
    end else begin
      for (int i = 0; i < NUM_SLOPE; i++) begin
        if (last[i]) begin
          result_r[i] <= result_nxt[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // overall maximum, cleared on read
  logic [TW-1:0] overall_r [NUM_SLOPE];
  logic [NUM_SLOPE-1:0] overall_rd;
  assign overall_rd[0] = i_reg_rd && (i_reg_addr == A_OVERALL_A);
  assign overall_rd[1] = i_reg_rd && (i_reg_addr == A_OVERALL_B);
  // update at period end; an update beats a read clear
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < NUM_SLOPE; i++) begin
        overall_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_SLOPE; i++) begin
        if (last[i]) begin
          overall_r[i] <= overall_rd[i] ? pmax_nxt[i]
                                        : max8(overall_r[i], pmax_nxt[i]);
        end else if (overall_rd[i]) begin
          overall_r[i] <= '0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slope status and alert
  logic [7:0] status_r;
  logic [7:0] status_set;
  logic status_rd;
  assign status_rd = i_reg_rd && (i_reg_addr == A_STATUS);
  // events raised by this cycle's conversion
  always_comb begin
    status_set = '0;
    status_set[ST_LIM1_BIT] = exceed[0];
    status_set[ST_LIM23_BIT] = exceed[1];
    status_set[ST_CHG1_BIT] = reversal[0];
    status_set[ST_CHG23_BIT] = reversal[1];
  end
  // sticky until read; a new event in the read cycle survives
  // the mask does not touch this register
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      status_r <= REG_RST;
    end else begin
      status_r <= (status_rd ? REG_RST : status_r) | status_set;
    end
  end
  // status then mask then pin; the count stage here is one hit
  // hottest change also drives the pin
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_alert_n <= 1'b1;
    end else begin
      o_alert_n <= !(o_hottest_changed ||
                     (!config_r[CFG_MASK_BIT] &&
                      (status_r[ST_LIM1_BIT] || status_r[ST_LIM23_BIT])));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read data
  // high byte holds the upper 8 of the 9 integer bits
  // shared low byte: ch23 lsb and fraction high, ch1 low
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reg_rdata <= REG_RST;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        A_GAIN: o_reg_rdata <= gain_r;
        A_CONFIG: o_reg_rdata <= config_r;
        A_STATUS: o_reg_rdata <= status_r;
        A_RES_HI_1: o_reg_rdata <= result_r[0][QW-1:FRAC_SHIFT+1];
        A_LIM_HI_1: o_reg_rdata <= lim_hi_r[0];
        A_LIM_LO_1: o_reg_rdata <= lim_lo_r[0];
        A_SAMPLES_1: o_reg_rdata <= samples_r[0];
        A_RES_HI_23: o_reg_rdata <= result_r[1][QW-1:FRAC_SHIFT+1];
        A_RES_LO: o_reg_rdata <= {result_r[1][FRAC_SHIFT:0],
                                  result_r[0][FRAC_SHIFT:0]};
        A_LIM_HI_23: o_reg_rdata <= lim_hi_r[1];
        A_LIM_LO_23: o_reg_rdata <= lim_lo_r[1];
        A_SAMPLES_23: o_reg_rdata <= samples_r[1];
        A_PERIOD_A: o_reg_rdata <= period_max_r[0];
        A_PERIOD_B: o_reg_rdata <= period_max_r[1];
        A_OVERALL_A: o_reg_rdata <= overall_r[0];
        A_OVERALL_B: o_reg_rdata <= overall_r[1];
        default: o_reg_rdata <= REG_RST;
      endcase
    end
  end

endmodule

//--- rtl/slope_mon_pkg.sv
// package for the hottest-channel and temperature slope monitor
// assumes an 8-bit register port and 8-bit temperature upper bytes
package slope_mon_pkg;

  // channel count and widths
  localparam int NUM_CH = 5;
  localparam int NUM_SLOPE = 2;
  localparam int TW = 8;
  localparam int QW = 12;  // 9 integer bits plus 3 fraction bits
  localparam int CW = 9;   // sample counter width

  // temperature channel indices
  localparam int CH_EXT1 = 1;
  localparam int CH_EXT2 = 2;
  localparam int CH_EXT3 = 3;

  // register offsets
  localparam logic [7:0] A_GAIN = 8'h3D;
  localparam logic [7:0] A_CONFIG = 8'h3E;
  localparam logic [7:0] A_STATUS = 8'h3F;
  localparam logic [7:0] A_RES_HI_1 = 8'h40;
  localparam logic [7:0] A_LIM_HI_1 = 8'h41;
  localparam logic [7:0] A_LIM_LO_1 = 8'h42;
  localparam logic [7:0] A_SAMPLES_1 = 8'h43;
  localparam logic [7:0] A_RES_HI_23 = 8'h44;
  localparam logic [7:0] A_RES_LO = 8'h45;
  localparam logic [7:0] A_LIM_HI_23 = 8'h46;
  localparam logic [7:0] A_LIM_LO_23 = 8'h47;
  localparam logic [7:0] A_SAMPLES_23 = 8'h48;
  localparam logic [7:0] A_PERIOD_A = 8'h49;
  localparam logic [7:0] A_PERIOD_B = 8'h4A;
  localparam logic [7:0] A_OVERALL_A = 8'h4D;
  localparam logic [7:0] A_OVERALL_B = 8'h4F;

  // field positions
  localparam int GAIN_CH1_LSB = 0;  // gain code bits [2:0], ch23 [5:3]
  localparam int GAIN_CH23_LSB = 3;
  localparam int GAIN_CW = 3;
  localparam int SAMP_CW = 3;       // samples = 2**code + 1
  localparam int CFG_MASK_BIT = 6;
  localparam int CFG_EN_BIT = 5;
  localparam int CFG_HYST_W = 4;    // hysteresis in bits [3:0]
  localparam int ST_LIM1_BIT = 7;
  localparam int ST_LIM23_BIT = 6;
  localparam int ST_CHG1_BIT = 5;
  localparam int ST_CHG23_BIT = 4;
  localparam int FRAC_SHIFT = 3;

  // reset values
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [CW-1:0] CNT_RST = 9'h000;
  localparam logic [QW-1:0] RES_RST = 12'h000;

  // saturation bounds of the slope result
  localparam logic signed [19:0] Q_MAX = 20'sh007FF;
  localparam logic signed [19:0] Q_MIN = -20'sh00800;

endpackage

//--- bench/slope_monitor_sva.sv
// checker for the slope monitor, sees only its top ports
// assumes one clock domain and the registered read port of the notes
module slope_monitor_sva
  import slope_mon_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // inputs watched
  input wire logic i_conv_done,
  input wire logic [7:0] i_temp_int,
  input wire logic [7:0] i_temp_ext1,
  input wire logic [7:0] i_temp_ext2,
  input wire logic [7:0] i_temp_ext3,
  input wire logic [7:0] i_temp_ext4,
  input wire logic [4:0] i_hot_select,
  input wire logic i_remember_hottest_enable,
  input wire logic i_hot_change_clear,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  // outputs watched
  input wire logic [7:0] o_reg_rdata,
  input wire logic [7:0] o_hottest_temp,
  input wire logic [4:0] o_hottest_status,
  input wire logic o_hottest_changed,
  input wire logic o_alert_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  logic [7:0] hot_max;
  logic [4:0] hot_mask;
  logic [7:0] t [5];
  ////////////////////////////////////////
  // expected winner; ties flag every matching channel
  always_comb begin
    t = '{i_temp_int, i_temp_ext1, i_temp_ext2, i_temp_ext3, i_temp_ext4};
    hot_max = 8'h00;
    for (int i = 0; i < 5; i++) begin
      if (i_hot_select[i] && t[i] > hot_max) hot_max = t[i];
    end
    for (int i = 0; i < 5; i++) begin
      hot_mask[i] = i_hot_select[i] && (t[i] == hot_max);
    end
  end
  ////////////////////////////////////////
  a_hot_value: assert property (
    i_conv_done && |i_hot_select |=> o_hottest_temp == $past(hot_max))
    else $error("hottest value wrong");
  a_hot_flags: assert property (
    i_conv_done && |i_hot_select |=> o_hottest_status == $past(hot_mask))
    else $error("hottest flags wrong");
  a_hot_hold: assert property (
    !i_conv_done |=> $stable(o_hottest_temp) && $stable(o_hottest_status))
    else $error("hottest outputs moved without conversion");
  a_hot_event: assert property (
    i_conv_done && i_remember_hottest_enable && |i_hot_select &&
    |o_hottest_status && hot_mask != o_hottest_status &&
    !i_hot_change_clear |=> o_hottest_changed)
    else $error("hottest change not flagged");
  a_no_event: assert property (
    !i_remember_hottest_enable && !o_hottest_changed |=> !o_hottest_changed)
    else $error("hottest change flagged while disabled");
  a_alert_hot: assert property (
    o_hottest_changed |=> !o_alert_n)
    else $error("alert missing after hottest change");
  // two reads in a row with no conversion: the second sees the cleared value
  a_stat_clear: assert property (
    (i_reg_rd && i_reg_addr == A_STATUS && !i_conv_done) [*2]
    |=> o_reg_rdata == 8'h00) else $error("status not cleared by read");
  a_peak_clear: assert property (
    (i_reg_rd && i_reg_addr == A_OVERALL_A && !i_conv_done) [*2]
    |=> o_reg_rdata == 8'h00) else $error("overall peak not cleared");
  a_res_hold: assert property (
    (i_reg_rd && i_reg_addr == A_RES_HI_1 && !i_conv_done) [*2]
    |=> o_reg_rdata == $past(o_reg_rdata)) else $error("result moved");
  a_rdata_hold: assert property (
    !i_reg_rd |=> $stable(o_reg_rdata)) else $error("read data moved");
  c_tie: cover property (i_conv_done ##1 $countones(o_hottest_status) > 1);
  c_event: cover property ($rose(o_hottest_changed));
  c_alert: cover property ($fell(o_alert_n));
  c_status: cover property (i_reg_rd && i_reg_addr == A_STATUS ##1
    o_reg_rdata != 8'h00);
endmodule
bind slope_monitor slope_monitor_sva u_sva (
  .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_conv_done(i_conv_done),
  .i_temp_int(i_temp_int), .i_temp_ext1(i_temp_ext1),
  .i_temp_ext2(i_temp_ext2), .i_temp_ext3(i_temp_ext3),
  .i_temp_ext4(i_temp_ext4), .i_hot_select(i_hot_select),
  .i_remember_hottest_enable(i_remember_hottest_enable),
  .i_hot_change_clear(i_hot_change_clear), .i_reg_rd(i_reg_rd),
  .i_reg_addr(i_reg_addr), .o_reg_rdata(o_reg_rdata),
  .o_hottest_temp(o_hottest_temp), .o_hottest_status(o_hottest_status),
  .o_hottest_changed(o_hottest_changed), .o_alert_n(o_alert_n));

//--- bench/host_model.sv
// host side of the register port of the slope monitor
// assumes requests launch on the falling edge and last whole cycles
module host_model (
  // clock
  input wire logic i_clk_sys,
  // register requests
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [7:0] o_reg_addr,
  output logic [7:0] o_reg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle host from time zero
  initial begin
    o_reg_wr = 1'h0;
    o_reg_rd = 1'h0;
    o_reg_addr = 8'h00;
    o_reg_wdata = 8'h00;
  end
  // one write; released lines show inverted garbage, not the old value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    o_reg_wr = 1'h1;
    o_reg_addr = a;
    o_reg_wdata = d;
    @(negedge i_clk_sys);
    o_reg_wr = 1'h0;
    o_reg_addr = ~a;
    o_reg_wdata = ~d;
  endtask
  // n back-to-back reads of one address, strobe held throughout
  task automatic rd(input logic [7:0] a, input int n);
    @(negedge i_clk_sys);
    o_reg_rd = 1'h1;
    o_reg_addr = a;
    repeat (n) @(negedge i_clk_sys);
    o_reg_rd = 1'h0;
    o_reg_addr = ~a;
  endtask
endmodule

//--- bench/testbench.sv
// self-checking bench for the hottest-of and slope monitor
// assumes host_model drives the register port; the bench drives the rest
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import slope_mon_pkg::*;
  `define CHK(nm, e, g) begin n_compared++; \
    if ((g) !== (e)) begin error_cnt++; \
      $display("BAD %s exp %h got %h", nm, e, g); end end
  typedef struct {logic [7:0] v; logic [4:0] s; string n;} note_t;
  int error_cnt = 0;
  int n_compared = 0;
  logic clk = 1'h0, rst = 1'h1, conv = 1'h0, rem = 1'h0, clr = 1'h0;
  logic ap = 1'h0, sr = 1'h0, rd_q = 1'h0, conv_q = 1'h0;
  logic [4:0] sel = 5'h1F;
  logic [7:0] tmp [5] = '{default: 8'h0A};
  logic [7:0] seq [5] = '{8'h19, 8'h23, 8'h1E, 8'h2D, 8'h23};
  logic [7:0] exp_st [3] = '{8'hF0, 8'hF0, 8'h80};
  logic reg_wr, reg_rd, hot_c, alert_n;
  logic [7:0] reg_addr, reg_wdata, rdata, hot_t;
  logic [4:0] hot_s;
  logic [31:0] lfsr_r = 32'h39079211;
  note_t reg_q [$];
  note_t hot_q [$];
  ////////////////////////////////////////
  // 10 MHz clock
  initial forever #50 clk = ~clk;
  host_model u_host_model (.i_clk_sys(clk), .o_reg_wr(reg_wr),
    .o_reg_rd(reg_rd), .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata));
  slope_monitor u_slope_monitor (.i_clk_sys(clk), .i_sys_rst(rst),
    .i_conv_done(conv), .i_temp_int(tmp[0]), .i_temp_ext1(tmp[1]),
    .i_temp_ext2(tmp[2]), .i_temp_ext3(tmp[3]), .i_temp_ext4(tmp[4]),
    .i_hot_select(sel), .i_remember_hottest_enable(rem),
    .i_hot_change_clear(clr), .i_second_anti_parallel(ap),
    .i_single_remote(sr), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(rdata),
    .o_hottest_temp(hot_t), .o_hottest_status(hot_s),
    .o_hottest_changed(hot_c), .o_alert_n(alert_n));
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return x[31] ? {x[30:0], 1'h0} ^ 32'h04C11DB7 : {x[30:0], 1'h0};
  endfunction
  task automatic give_verdict();
    if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  // note the expected read data, then let the host read n times
  task automatic rd_n(input string nm, input logic [7:0] a,
    input logic [7:0] e1, input logic [7:0] e2, input int n);
    note_t x;
    x.n = nm;
    x.s = 5'h00;
    x.v = e1;
    reg_q.push_back(x);
    x.v = e2;
    if (n == 2) reg_q.push_back(x);
    u_host_model.rd(a, n);
  endtask
  // note the expected hottest result, then pulse one conversion
  task automatic conv_once();
    note_t x;
    x.n = "hottest";
    x.v = 8'h00;
    for (int i = 0; i < 5; i++) begin
      if (sel[i] && tmp[i] > x.v) x.v = tmp[i];
    end
    for (int i = 0; i < 5; i++) x.s[i] = sel[i] && (tmp[i] == x.v);
    hot_q.push_back(x);
    @(negedge clk);
    conv = 1'h1;
    @(negedge clk);
    conv = 1'h0;
  endtask
  ////////////////////////////////////////
  // remember which edges launched a read or a conversion
  always @(posedge clk) begin
    rd_q <= reg_rd;
    conv_q <= conv;
  end
  // compare each result as it appears with the oldest note
  always @(negedge clk) begin
    note_t x;
    if (rd_q && reg_q.size() > 0) begin
      x = reg_q.pop_front();
      `CHK(x.n, x.v, rdata)
    end
    if (conv_q && hot_q.size() > 0) begin
      x = hot_q.pop_front();
      `CHK(x.n, x.v, hot_t)
      `CHK(x.n, x.s, hot_s)
    end
  end
  // a hang counts as a mismatch
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
  ////////////////////////////////////////
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'h0;
    rd_n("status", A_STATUS, 8'h00, 8'h00, 1);
    rd_n("overall", A_OVERALL_A, 8'h00, 8'h00, 1);
    u_host_model.wr(A_STATUS, 8'hFF);
    rd_n("status ro", A_STATUS, 8'h00, 8'h00, 1);
    rd_n("unmapped", 8'h50, 8'h00, 8'h00, 1);
    `CHK("alert", 1'h1, alert_n)
    // random rounds over a narrow range so ties are common
    for (int k = 0; k < 24; k++) begin
      lfsr_r = lfsr(lfsr_r);
      sel = (lfsr_r[31:27] == 5'h00) ? 5'h1F : lfsr_r[31:27];
      for (int i = 0; i < 5; i++) tmp[i] = 8'h20 + lfsr_r[3*i +: 3];
      conv_once();
    end
    step(1);
    `CHK("changed", 1'h0, hot_c)
    // hottest channel change with the event enabled
    sel = 5'h1F;
    tmp = '{8'h14, 8'h3C, 8'h14, 8'h14, 8'h14};
    rem = 1'h1;
    conv_once();
    clr = 1'h1;
    step(1);
    clr = 1'h0;
    conv_once();
    step(1);
    `CHK("changed", 1'h0, hot_c)
    `CHK("alert", 1'h1, alert_n)
    tmp[3] = 8'h46;
    conv_once();
    `CHK("changed", 1'h1, hot_c)
    step(1);
    `CHK("alert", 1'h0, alert_n)
    rem = 1'h0;
    clr = 1'h1;
    step(1);
    clr = 1'h0;
    step(2);
    `CHK("alert", 1'h1, alert_n)
    // slope setup: gain two, five samples, limit two on both channels
    u_host_model.wr(A_GAIN, 8'h09);
    u_host_model.wr(A_SAMPLES_1, 8'h02);
    u_host_model.wr(A_SAMPLES_23, 8'h02);
    u_host_model.wr(A_LIM_HI_1, 8'h01);
    u_host_model.wr(A_LIM_HI_23, 8'h01);
    rd_n("gain", A_GAIN, 8'h09, 8'h00, 1);
    rd_n("samples", A_SAMPLES_23, 8'h02, 8'h00, 1);
    rd_n("limit", A_LIM_HI_23, 8'h01, 8'h00, 1);
    // plain, anti-parallel with mask, then single remote with hysteresis
    // wide enough to hide every reversal of the sequence
    for (int p = 0; p < 3; p++) begin
      ap = (p == 1);
      sr = (p == 2);
      u_host_model.wr(A_CONFIG, (p == 1) ? 8'h60 : (p == 2) ? 8'h2F : 8'h20);
      for (int s = 0; s < 5; s++) begin
        tmp = '{8'h0A, seq[s], (p != 1) ? seq[s] : 8'h14,
          (p == 1) ? seq[s] : 8'h14, 8'h0A};
        conv_once();
        if (p == 0 && s == 3) rd_n("early", A_RES_HI_1, 8'h00, 8'h00, 1);
      end
      step(1);
      `CHK("alert", (p == 1) ? 1'h1 : 1'h0, alert_n)
      rd_n("status", A_STATUS, exp_st[p], 8'h00, 2);
      rd_n("result1", A_RES_HI_1, 8'h02, 8'h02, 2);
      if (p < 2) rd_n("result23", A_RES_HI_23, 8'h02, 8'h00, 1);
      if (p == 0) begin
        rd_n("low", A_RES_LO, 8'h88, 8'h00, 1);
        rd_n("period", A_PERIOD_A, 8'h2D, 8'h00, 1);
        rd_n("overall", A_OVERALL_A, 8'h2D, 8'h00, 2);
        rd_n("period b", A_PERIOD_B, 8'h2D, 8'h00, 1);
        rd_n("overall b", A_OVERALL_B, 8'h2D, 8'h00, 2);
      end
      `CHK("alert", 1'h1, alert_n)
    end
    step(2);
    give_verdict();
  end
endmodule
